//--- settings_set_sequencer.sv
// Configuration-set save/load logic and flat-field sequencer with its register port.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Notes on behaviour
// - Set selector picks factory, first user or second user set.
// - Load command copies the selected set into the working set.
// - Save command writes the working set into the selected user set.
// - Factory set may be loaded but a save to it is refused.
// - Two save targets and three load sources exist.
// - After reset the startup-chosen set is applied.
// - Unsaved working values are lost on reset or power loss.
// - Saved sequencer sets come back after reset via the startup choice.
// - While running, sets are applied one after another per image.
// - Sequencer sets are indexed 0 to 31, thirty-two in all.
// - Each sequencer set holds only a flat-field table choice.
// - Run enable starts the sequencer when set with triggered acquisition on and edit mode off; clear stops it.
// - Edit mode allows sets to be edited; host orders mode changes.
// - Edit index 0 to 31 chooses which set later writes configure.
// - A read-only field shows the index of the set in effect.
// - Set total 1 to 32 decides how many sets are cycled.
// - Restart command returns the active set to index 0 at once.
// ------------------------------------------------------------------
module settings_set_sequencer
  import settings_set_pkg::*;
(
  // Clock, device reset, power-up reset and clock enable.
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_N_I,
  input wire logic CE_I,
  // Register port.
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [DATA_W-1:0] REG_RDATA_O,
  // Acquisition side.
  input wire logic TRIG_I,
  output logic [FFC_W-1:0] FFC_SEL_O,
  output logic [IDX_W-1:0] SEQ_INDEX_O,
  output logic SEQ_ACTIVE_O
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Maps a set code to its stored contents; an unknown code reads as factory.
  function automatic cfg_set_t pick_set(input logic [1:0] code, input nv_state_t nv);
    cfg_set_t res;
    res = FACTORY_SET;
    case (code)
      SET_FIRST_USER: res = nv.first_user_set;
      SET_SECOND_USER: res = nv.second_user_set;
      default: res = FACTORY_SET;
    endcase
    return res;
  endfunction

  // Next index in the cycle, wrapping after the last configured set.
  function automatic logic [IDX_W-1:0] step_index(input logic [IDX_W-1:0] cur,
                                                  input logic [IDX_W-1:0] last);
    logic [IDX_W-1:0] res;
    res = IDX_ZERO;
    if (cur < last) begin
      res = cur + 5'h01;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  work_state_t st_r;
  work_state_t st_nxt;
  nv_state_t nv_r;
  nv_state_t nv_nxt;
  reg_req_t req;
  logic wr_hit_ctrl;
  logic wr_hit_cfg;
  logic wr_hit_cmd;
  logic wr_hit_edit;
  logic wr_hit_ffc;
  logic wr_hit_total;
  logic [5:0] total_req;
  logic [5:0] total_clamped;
  logic running;

  // Request bundle and address decode of writes.
  assign req = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, wr: REG_WR_I, rd: REG_RD_I};
  assign wr_hit_ctrl = req.wr && (req.addr == CTRL_OFS);
  assign wr_hit_cfg = req.wr && (req.addr == CFG_SET_OFS);
  assign wr_hit_cmd = req.wr && (req.addr == CMD_OFS);
  assign wr_hit_edit = req.wr && (req.addr == EDIT_INDEX_OFS);
  assign wr_hit_ffc = req.wr && (req.addr == FFC_CHOICE_OFS);
  assign wr_hit_total = req.wr && (req.addr == SET_TOTAL_OFS);

  // Set total is stored less one; out-of-range writes clamp to 1 or 32.
  assign total_req = req.wdata[5:0];
  assign total_clamped = (total_req < TOTAL_MIN) ? TOTAL_MIN :
                         (total_req > TOTAL_MAX) ? TOTAL_MAX : total_req;

  // Triggers only count when the host has triggered acquisition on.
  assign running = st_r.seq_run_enable && st_r.triggered_acq_enable;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // All register, command and sequencer effects in one place so that
  // their priorities are visible together.
  always_comb begin
    st_nxt = st_r;
    nv_nxt = nv_r;
    st_nxt.rdata = '0;

    // The first enabled cycle after reset applies the startup set, so
    // whatever was unsaved in the working set is gone.
    if (st_r.boot_pending) begin
      st_nxt.work = pick_set(nv_r.startup_set_choice, nv_r);
      st_nxt.boot_pending = 1'b0;
      st_nxt.booted = 1'b1;
    end

    // Control bits.
    if (wr_hit_ctrl) begin
      st_nxt.seq_run_enable = req.wdata[CTRL_RUN_BIT];
      st_nxt.seq_edit_mode = req.wdata[CTRL_EDIT_BIT];
      st_nxt.triggered_acq_enable = req.wdata[CTRL_TRIG_BIT];
    end

    // Set selector lives in the working space; the startup choice is kept
    // with the stored sets so that it outlives a device reset.
    if (wr_hit_cfg) begin
      st_nxt.config_set_select = req.wdata[CFG_SELECT_LSB +: 2];
      nv_nxt.startup_set_choice = req.wdata[CFG_STARTUP_LSB +: 2];
    end

    if (wr_hit_edit) begin
      st_nxt.seq_edit_index = req.wdata[IDX_W-1:0];
    end

    // Table writes land only in edit mode; outside it they are dropped so
    // a running sequence is never disturbed mid-cycle.
    if (wr_hit_ffc && st_r.seq_edit_mode) begin
      st_nxt.work.ffc_table[st_r.seq_edit_index] = req.wdata[FFC_W-1:0];
    end

    if (wr_hit_total) begin
      st_nxt.work.total_m1 = IDX_W'(total_clamped - TOTAL_MIN);
    end

    // Load from any of the three sources.
    if (wr_hit_cmd && req.wdata[CMD_LOAD_BIT]) begin
      st_nxt.work = pick_set(st_r.config_set_select, nv_r);
    end

    // Save only to the two user sets; the factory set stays untouched.
    if (wr_hit_cmd && req.wdata[CMD_SAVE_BIT]) begin
      case (st_r.config_set_select)
        SET_FIRST_USER: begin
          nv_nxt.first_user_set = st_r.work;
          st_nxt.save_refused = 1'b0;
        end
        SET_SECOND_USER: begin
          nv_nxt.second_user_set = st_r.work;
          st_nxt.save_refused = 1'b0;
        end
        default: begin
          st_nxt.save_refused = 1'b1;
        end
      endcase
    end

    // Sequencer stepping; restart has priority over a same-cycle trigger.
    if (wr_hit_cmd && req.wdata[CMD_RESTART_BIT]) begin
      st_nxt.seq_current_index = IDX_ZERO;
    end else if (running && !st_r.seq_edit_mode && TRIG_I) begin
      st_nxt.seq_current_index = step_index(st_r.seq_current_index,
                                            st_r.work.total_m1);
    end else if (st_r.seq_current_index > st_nxt.work.total_m1) begin
      // A smaller total or a load must not leave the index out of range.
      st_nxt.seq_current_index = IDX_ZERO;
    end

    // Table choice of the set in effect, taken from the next values so it
    // follows an index step in the same edge.
    st_nxt.ffc_sel = st_nxt.work.ffc_table[st_nxt.seq_current_index];

    // Read data for the cycle after the strobe; unmapped offsets read zero.
    if (req.rd) begin
      case (req.addr)
        CTRL_OFS: begin
          st_nxt.rdata[CTRL_RUN_BIT] = st_r.seq_run_enable;
          st_nxt.rdata[CTRL_EDIT_BIT] = st_r.seq_edit_mode;
          st_nxt.rdata[CTRL_TRIG_BIT] = st_r.triggered_acq_enable;
        end
        CFG_SET_OFS: begin
          st_nxt.rdata[CFG_SELECT_LSB +: 2] = st_r.config_set_select;
          st_nxt.rdata[CFG_STARTUP_LSB +: 2] = nv_r.startup_set_choice;
        end
        EDIT_INDEX_OFS: begin
          st_nxt.rdata[IDX_W-1:0] = st_r.seq_edit_index;
        end
        FFC_CHOICE_OFS: begin
          st_nxt.rdata[FFC_W-1:0] = st_r.work.ffc_table[st_r.seq_edit_index];
        end
        SET_TOTAL_OFS: begin
          st_nxt.rdata[5:0] = 6'(st_r.work.total_m1) + TOTAL_MIN;
        end
        STATUS_OFS: begin
          st_nxt.rdata[STATUS_IDX_LSB +: IDX_W] = st_r.seq_current_index;
          st_nxt.rdata[STATUS_REFUSED_BIT] = st_r.save_refused;
          st_nxt.rdata[STATUS_BOOTED_BIT] = st_r.booted;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Working state: device reset clears it and arms the startup load.
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_r <= '{work: FACTORY_SET, config_set_select: SET_FACTORY,
                seq_edit_index: IDX_ZERO, seq_current_index: IDX_ZERO,
                ffc_sel: FFC_FACTORY, rdata: '0, boot_pending: 1'b1,
                default: 1'b0};
    end else if (CE_I) begin
      st_r <= st_nxt;
    end
  end

  // Stored sets: only power-up clears them, to factory contents, which
  // stands in for a blank non-volatile store.
  always_ff @(posedge REF_CLK_I or negedge POWER_N_I) begin
    if (!POWER_N_I) begin
      nv_r <= '{first_user_set: FACTORY_SET, second_user_set: FACTORY_SET,
                startup_set_choice: SET_FACTORY};
    end else if (CE_I) begin
      nv_r <= nv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_O = st_r.rdata;
  assign FFC_SEL_O = st_r.ffc_sel;
  assign SEQ_INDEX_O = st_r.seq_current_index;
  assign SEQ_ACTIVE_O = running && !st_r.seq_edit_mode;

endmodule
`default_nettype wire

//--- settings_set_pkg.sv
// Package with the constants and types of the configuration-set sequencer.
package settings_set_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FFC_W = 4;
  localparam int IDX_W = 5;
  localparam int SEQ_SETS = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_SET_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] EDIT_INDEX_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FFC_CHOICE_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] SET_TOTAL_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EDIT_BIT = 1;
  localparam int CTRL_TRIG_BIT = 2;
  localparam int CFG_SELECT_LSB = 0;
  localparam int CFG_STARTUP_LSB = 4;
  localparam int CMD_LOAD_BIT = 0;
  localparam int CMD_SAVE_BIT = 1;
  localparam int CMD_RESTART_BIT = 2;
  localparam int STATUS_IDX_LSB = 0;
  localparam int STATUS_REFUSED_BIT = 8;
  localparam int STATUS_BOOTED_BIT = 9;

  // ----------------------------------------------------------------
  // Set codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SET_FACTORY = 2'h0;
  localparam logic [1:0] SET_FIRST_USER = 2'h1;
  localparam logic [1:0] SET_SECOND_USER = 2'h2;
  localparam logic [IDX_W-1:0] IDX_ZERO = 5'h00;
  localparam logic [IDX_W-1:0] TOTAL_M1_FACTORY = 5'h00;
  localparam logic [FFC_W-1:0] FFC_FACTORY = 4'h0;
  localparam logic [5:0] TOTAL_MIN = 6'h01;
  localparam logic [5:0] TOTAL_MAX = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // One configuration set: set count less one and the per-set table.
  typedef struct packed {
    logic [IDX_W-1:0] total_m1;
    logic [SEQ_SETS-1:0][FFC_W-1:0] ffc_table;
  } cfg_set_t;

  // Register port request as seen by the block.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Contents that survive a device reset and are lost only at power-up.
  typedef struct packed {
    cfg_set_t first_user_set;
    cfg_set_t second_user_set;
    logic [1:0] startup_set_choice;
  } nv_state_t;

  // Volatile working state, cleared by the device reset.
  typedef struct packed {
    cfg_set_t work;
    logic [1:0] config_set_select;
    logic seq_run_enable;
    logic seq_edit_mode;
    logic triggered_acq_enable;
    logic [IDX_W-1:0] seq_edit_index;
    logic [IDX_W-1:0] seq_current_index;
    logic [FFC_W-1:0] ffc_sel;
    logic save_refused;
    logic boot_pending;
    logic booted;
    logic [DATA_W-1:0] rdata;
  } work_state_t;

  localparam cfg_set_t FACTORY_SET = '{total_m1: TOTAL_M1_FACTORY, ffc_table: '0};

endpackage

//--- settings_set_chk.sv
// Checker of the set sequencer port behaviour, bound to the settings_set_sequencer module.
`timescale 1ns/100ps
`default_nettype none
module settings_set_chk
  import settings_set_pkg::*;
(
  // Clock, resets and enable.
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_N_I,
  input wire logic CE_I,
  // Register port.
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [DATA_W-1:0] REG_RDATA_O,
  // Acquisition side.
  input wire logic TRIG_I,
  input wire logic [FFC_W-1:0] FFC_SEL_O,
  input wire logic [IDX_W-1:0] SEQ_INDEX_O,
  input wire logic SEQ_ACTIVE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I || !POWER_N_I);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Requests count only on enabled edges, so each sequence carries CE_I.
  sequence restart_s;
    CE_I && REG_WR_I && REG_ADDR_I == CMD_OFS && REG_WDATA_I[CMD_RESTART_BIT];
  endsequence
  sequence trig_s;
    CE_I && TRIG_I && SEQ_ACTIVE_O && !REG_WR_I;
  endsequence
  sequence status_rd_s;
    CE_I && REG_RD_I && REG_ADDR_I == STATUS_OFS;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The index wraps to zero after the last set, hence the zero escape.
  a_trig_step: assert property (trig_s |=> SEQ_INDEX_O == $past(SEQ_INDEX_O) + 5'h01
    || SEQ_INDEX_O == IDX_ZERO) else $error("index did not step on trigger");
  a_restart_zero: assert property (restart_s |=> SEQ_INDEX_O == IDX_ZERO)
    else $error("restart did not clear index");
  a_idle_hold: assert property (CE_I && !(TRIG_I && SEQ_ACTIVE_O) && !REG_WR_I
    |=> $stable(SEQ_INDEX_O)) else $error("index moved without trigger");
  a_ce_freeze: assert property (!CE_I |=> $stable(SEQ_INDEX_O) && $stable(FFC_SEL_O))
    else $error("outputs moved with clock enable low");
  a_ctrl_active: assert property (CE_I && REG_WR_I && REG_ADDR_I == CTRL_OFS
    |=> SEQ_ACTIVE_O == ($past(REG_WDATA_I[2:0]) == 3'b101)) else $error("active flag wrong");
  a_status_idx: assert property (status_rd_s |=> REG_RDATA_O[4:0] == $past(SEQ_INDEX_O)
    && REG_RDATA_O[31:10] == '0) else $error("status index wrong");
  a_rdata_zero: assert property (CE_I && !REG_RD_I |=> REG_RDATA_O == '0)
    else $error("read data outside read answer");
  a_cmd_wo: assert property (CE_I && REG_RD_I && REG_ADDR_I == CMD_OFS |=> REG_RDATA_O == '0)
    else $error("command word read not zero");
endmodule
bind settings_set_sequencer settings_set_chk chk_i (.REF_CLK_I(REF_CLK_I),
  .RESET_N_I(RESET_N_I), .POWER_N_I(POWER_N_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .TRIG_I(TRIG_I), .FFC_SEL_O(FFC_SEL_O),
  .SEQ_INDEX_O(SEQ_INDEX_O), .SEQ_ACTIVE_O(SEQ_ACTIVE_O));
`default_nettype wire

//--- settings_set_sequencer_tb_top.sv
// Self-checking testbench of the configuration-set sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module settings_set_sequencer_tb_top
  import settings_set_pkg::*;
;
  logic REF_CLK_I, RESET_N_I, POWER_N_I, CE_I, REG_WR_I, REG_RD_I, TRIG_I, SEQ_ACTIVE_O;
  logic [ADDR_W-1:0] REG_ADDR_I;
  logic [DATA_W-1:0] REG_WDATA_I, REG_RDATA_O, rv;
  logic [FFC_W-1:0] FFC_SEL_O;
  logic [IDX_W-1:0] SEQ_INDEX_O;
  int err_count, checks_done, i;
  settings_set_sequencer uut (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
    .POWER_N_I(POWER_N_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .TRIG_I(TRIG_I),
    .FFC_SEL_O(FFC_SEL_O), .SEQ_INDEX_O(SEQ_INDEX_O), .SEQ_ACTIVE_O(SEQ_ACTIVE_O));
  // ----------------------------------------------------------------
  // Bus and trigger tasks
  // ----------------------------------------------------------------
  // The bus and trigger tasks end at a falling edge so outputs are settled when sampled.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'b0;
    @(negedge REF_CLK_I);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'b0;
    @(negedge REF_CLK_I);
    rv = REG_RDATA_O;
    `CHK(rv, e)
  endtask
  task automatic trig;
    @(posedge REF_CLK_I);
    TRIG_I <= 1'b1;
    @(posedge REF_CLK_I);
    TRIG_I <= 1'b0;
    @(negedge REF_CLK_I);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Four table entries, count four, six images so the index wraps once.
  task automatic t_cycle;
    wr(CTRL_OFS, 32'h2);
    for (i = 0; i < 4; i++) begin
      wr(EDIT_INDEX_OFS, i);
      wr(FFC_CHOICE_OFS, i + 9);
    end
    wr(SET_TOTAL_OFS, 32'h4);
    wr(CTRL_OFS, 32'h5);
    for (i = 1; i < 6; i++) begin
      trig();
      `CHK(SEQ_INDEX_O, IDX_W'(i % 4))
      `CHK(FFC_SEL_O, FFC_W'(9 + i % 4))
    end
    trig();
    wr(CMD_OFS, 32'h4);
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    rdc(STATUS_OFS, 32'h200);
    rdc(CMD_OFS, 32'h0);
  endtask
  // Triggers must be ignored unless run, trigger mode and no edit are all set.
  task automatic t_gate;
    wr(CTRL_OFS, 32'h1);
    trig();
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    wr(CTRL_OFS, 32'h4);
    trig();
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    wr(CTRL_OFS, 32'h7);
    trig();
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    wr(CTRL_OFS, 32'h5);
    @(posedge REF_CLK_I);
    CE_I <= 1'b0;
    trig();
    @(posedge REF_CLK_I);
    CE_I <= 1'b1;
    @(negedge REF_CLK_I);
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    wr(EDIT_INDEX_OFS, 32'h0);
    wr(FFC_CHOICE_OFS, 32'h3);
    rdc(FFC_CHOICE_OFS, 32'h9);
  endtask
  // Count clamps at both ends; the top count walks through index 31.
  task automatic t_total;
    wr(SET_TOTAL_OFS, 32'h0);
    rdc(SET_TOTAL_OFS, 32'h1);
    wr(SET_TOTAL_OFS, 32'h21);
    rdc(SET_TOTAL_OFS, 32'h20);
    for (i = 0; i < 31; i++) trig();
    `CHK(SEQ_INDEX_O, 5'h1F)
    trig();
    `CHK(SEQ_INDEX_O, IDX_ZERO)
    wr(SET_TOTAL_OFS, 32'h4);
  endtask
  // Save refusals, saves to both user sets, loads of factory and second user set, then the startup set after reset.
  task automatic t_sets;
    wr(CFG_SET_OFS, 32'h0);
    wr(CMD_OFS, 32'h2);
    rdc(STATUS_OFS, 32'h300);
    wr(CFG_SET_OFS, 32'h3);
    wr(CMD_OFS, 32'h2);
    rdc(STATUS_OFS, 32'h300);
    wr(CFG_SET_OFS, 32'h1);
    wr(CMD_OFS, 32'h2);
    rdc(STATUS_OFS, 32'h200);
    wr(CFG_SET_OFS, 32'h2);
    wr(CMD_OFS, 32'h2);
    wr(CFG_SET_OFS, 32'h0);
    wr(CMD_OFS, 32'h1);
    rdc(SET_TOTAL_OFS, 32'h1);
    rdc(FFC_CHOICE_OFS, 32'h0);
    wr(CFG_SET_OFS, 32'h2);
    wr(CMD_OFS, 32'h1);
    rdc(SET_TOTAL_OFS, 32'h4);
    rdc(FFC_CHOICE_OFS, 32'h9);
    wr(CTRL_OFS, 32'h2);
    wr(FFC_CHOICE_OFS, 32'h5);
    wr(CFG_SET_OFS, 32'h10);
    @(posedge REF_CLK_I);
    RESET_N_I <= 1'b0;
    repeat (3) @(posedge REF_CLK_I);
    RESET_N_I <= 1'b1;
    @(negedge REF_CLK_I);
    rdc(SET_TOTAL_OFS, 32'h4);
    rdc(FFC_CHOICE_OFS, 32'h9);
    rdc(CTRL_OFS, 32'h0);
    rdc(CFG_SET_OFS, 32'h10);
    `CHK(FFC_SEL_O, 4'h9)
    // A power-up blanks the stored sets, so the factory set comes back.
    @(posedge REF_CLK_I);
    RESET_N_I <= 1'b0;
    POWER_N_I <= 1'b0;
    repeat (3) @(posedge REF_CLK_I);
    RESET_N_I <= 1'b1;
    POWER_N_I <= 1'b1;
    @(negedge REF_CLK_I);
    rdc(CFG_SET_OFS, 32'h0);
    rdc(SET_TOTAL_OFS, 32'h1);
    rdc(FFC_CHOICE_OFS, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    REF_CLK_I = 1'b0;
    forever #4 REF_CLK_I = ~REF_CLK_I;
  end
  // A hang ends the run as a mismatch instead of stalling forever.
  initial begin
    repeat (20000) @(posedge REF_CLK_I);
    err_count++;
    conclude();
  end
  initial begin
    err_count = 0;
    checks_done = 0;
    RESET_N_I = 1'b0;
    POWER_N_I = 1'b0;
    CE_I = 1'b1;
    REG_ADDR_I = '0;
    REG_WDATA_I = '0;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    TRIG_I = 1'b0;
    repeat (3) @(posedge REF_CLK_I);
    RESET_N_I <= 1'b1;
    POWER_N_I <= 1'b1;
    @(negedge REF_CLK_I);
    rdc(STATUS_OFS, 32'h200);
    rdc(SET_TOTAL_OFS, 32'h1);
    t_cycle();
    t_gate();
    t_total();
    t_sets();
    conclude();
  end
endmodule
`default_nettype wire
